/* File: lscr_map.svh */
// Constants for the supply control status register block
`ifndef LSCR_MAP_SVH
`define LSCR_MAP_SVH
// ==========================================
// Register bit positions
`define LSCR_BIT_STYLE 7
`define LSCR_BIT_LEVEL 6
`define LSCR_BIT_TONE 5
`define LSCR_BIT_COMP 4
`define LSCR_BIT_VOLTAGE_SEL 3
`define LSCR_BIT_EN 2
`define LSCR_BIT_THERM 1
`define LSCR_BIT_OVLD 0
`define LSCR_REG_RESET 8'h00
`define LSCR_WR_MASK 8'hFC
`define LSCR_SYNC_RESET 7'h60
// ==========================================
// Bus address and framing
`define LSCR_DEV_ADDR 7'h08
`define LSCR_BITS_PER_BYTE 4'h8
`define LSCR_BIT_LAST 4'h7
// ==========================================
// Output voltage codes {comp, voltage_sel}
`define LSCR_VOUT_13 2'h0
`define LSCR_VOUT_18 2'h1
`define LSCR_VOUT_14 2'h2
`define LSCR_VOUT_19 2'h3
`endif

/* File: lscr_pkg.sv */
// Types for the supply control status register block
package lscr_pkg;
  typedef enum logic [2:0] {
    LSCR_IDLE = 3'b000,
    LSCR_ADDR = 3'b001,
    LSCR_AACK = 3'b010,
    LSCR_WDAT = 3'b011,
    LSCR_WACK = 3'b100,
    LSCR_RDAT = 3'b101,
    LSCR_RACK = 3'b110
  } lscr_state_type;
endpackage : lscr_pkg

/* File: lscr_sync.sv */
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
module lscr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [WIDTH-1:0] asyncIn,
  input wire logic [WIDTH-1:0] resetVal,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  // ==========================================
  // Synchroniser stages
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage1_ff <= resetVal;
      stage2_ff <= resetVal;
    end else if (clkEn) begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign syncOut = stage2_ff;
endmodule : lscr_sync

/* File: lscr_power_ctrl.sv */
// Decodes register controls into supply block commands
`timescale 1ns/10ps
`include "lscr_map.svh"
module lscr_power_ctrl (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [7:0] regVal,
  input wire logic toneGateIn,
  input wire logic thermalHot,
  input wire logic lockout,
  output logic powerOn,
  output logic loopThroughClosed,
  output logic [1:0] voutCode,
  output logic toneOn,
  output logic limitLow,
  output logic limitStatic
);
  logic enable;
  assign enable = regVal[`LSCR_BIT_EN] && !lockout;

  // ==========================================
  // Registered supply commands
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      powerOn <= 1'b0;
      loopThroughClosed <= 1'b1;
      voutCode <= `LSCR_VOUT_13;
      toneOn <= 1'b0;
      limitLow <= 1'b0;
      limitStatic <= 1'b0;
    end else if (clkEn) begin
      powerOn <= enable && !thermalHot;
      loopThroughClosed <= !enable;
      voutCode <= {regVal[`LSCR_BIT_COMP], regVal[`LSCR_BIT_VOLTAGE_SEL]};
      toneOn <= enable && !thermalHot &&
        (regVal[`LSCR_BIT_TONE] || toneGateIn);
      limitLow <= regVal[`LSCR_BIT_LEVEL];
      limitStatic <= regVal[`LSCR_BIT_STYLE];
    end
  end
endmodule : lscr_power_ctrl

/* File: lscr_supply_ctrl.sv */
// Supply control register with its two-wire slave port and tone pins
// Contract
// - Eight bits: style, level, tone, comp, voltage_sel, enable, thermal, overload.
// - Power-on clears every register bit.
// - Direction bit zero writes the next byte into six writable bits.
// - Comp and voltage_sel pick one of four output voltages when enabled.
// - Tone force runs carrier; else the tone gate pin keys it.
// - Limit level bit picks the current-limit window.
// - Limit style bit picks pulsed or static limiting.
// - Enable clear disables power and closes the loop-through switch.
// - Direction bit one reads the register out, MSB first.
// - Master ack on ninth clock requests another byte; nack ends.
// - Readback returns written bits plus live flags.
// - Thermal flag shows overheating; power then disabled, switch open.
// - Overload flag shows triggered overload protection.
// - Under lockout ignore commands, hold register zero, power off.
// - Interface works only after supply rises above lockout.
// - Tone data uses the gate input and detect output pins.
// - Tone detect output is open drain, low while tone detected.
// - Transfer is start, address 10h/11h, data byte with ack, stop.
// - Device acks each received byte on the ninth clock.
`timescale 1ns/10ps
`include "lscr_map.svh"
module lscr_supply_ctrl (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n,
  input wire logic lockoutIn,
  input wire logic thermalIn,
  input wire logic overloadIn,
  input wire logic toneSensedIn,
  input wire logic tone_gate_in,
  output logic tone_detect_out,
  output logic tone_detect_oe_n,
  output logic [7:0] supply_control_status,
  output logic powerOn,
  output logic loopThroughClosed,
  output logic [1:0] voutCode,
  output logic toneOn,
  output logic limitLow,
  output logic limitStatic
);
  import lscr_pkg::*;

  logic [6:0] syncIn;
  logic scl;
  logic sda;
  logic lockout;
  logic thermal;
  logic overload;
  logic toneSensed;
  logic toneGate;
  logic sclPrev_ff;
  logic sdaPrev_ff;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  lscr_state_type state_ff;
  lscr_state_type nxt_state;
  logic [3:0] bitCnt_ff;
  logic [7:0] shift_ff;
  logic readDir_ff;
  logic [7:0] regBits_ff;
  logic [7:0] readByte;
  logic nextReadBit;
  logic sdaHoldLow_ff;
  logic toneLow_ff;

  // ==========================================
  // Pin synchronisers
  lscr_sync #(.WIDTH(7)) uSync (
    .clock(clock),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .asyncIn({sclIn, sdaIn, lockoutIn, thermalIn, overloadIn,
      toneSensedIn, tone_gate_in}),
    .resetVal(`LSCR_SYNC_RESET),
    .syncOut(syncIn)
  );
  assign {scl, sda, lockout, thermal, overload, toneSensed, toneGate} = syncIn;

  // ==========================================
  // Clock line history
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sclPrev_ff <= 1'b1;
    end else if (clkEn) begin
      sclPrev_ff <= scl;
    end
  end

  // ==========================================
  // Data line history
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sdaPrev_ff <= 1'b1;
    end else if (clkEn) begin
      sdaPrev_ff <= sda;
    end
  end

  assign sclRise = scl && !sclPrev_ff;
  assign sclFall = !scl && sclPrev_ff;
  assign startSeen = scl && sclPrev_ff && sdaPrev_ff && !sda;
  assign stopSeen = scl && sclPrev_ff && !sdaPrev_ff && sda;

  // ==========================================
  // Live flags merged with written bits
  always_comb begin
    readByte = regBits_ff & `LSCR_WR_MASK;
    readByte[`LSCR_BIT_THERM] = thermal;
    readByte[`LSCR_BIT_OVLD] = overload;
  end

  // ==========================================
  // Next read data bit
  always_comb begin
    if (state_ff != LSCR_RDAT) begin
      nextReadBit = readByte[7];
    end else if (sclFall) begin
      nextReadBit = shift_ff[6];
    end else begin
      nextReadBit = shift_ff[7];
    end
  end

  // ==========================================
  // Transfer state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      LSCR_IDLE: begin
        nxt_state = LSCR_IDLE;
      end
      LSCR_ADDR: begin
        if (sclFall && bitCnt_ff == `LSCR_BITS_PER_BYTE) begin
          if (shift_ff[7:1] == `LSCR_DEV_ADDR) begin
            nxt_state = LSCR_AACK;
          end else begin
            nxt_state = LSCR_IDLE;
          end
        end
      end
      LSCR_AACK: begin
        if (sclFall) begin
          nxt_state = readDir_ff ? LSCR_RDAT : LSCR_WDAT;
        end
      end
      LSCR_WDAT: begin
        if (sclFall && bitCnt_ff == `LSCR_BITS_PER_BYTE) begin
          nxt_state = LSCR_WACK;
        end
      end
      LSCR_WACK: begin
        if (sclFall) begin
          nxt_state = LSCR_WDAT;
        end
      end
      LSCR_RDAT: begin
        if (sclFall && bitCnt_ff == `LSCR_BITS_PER_BYTE) begin
          nxt_state = LSCR_RACK;
        end
      end
      LSCR_RACK: begin
        if (sclRise) begin
          nxt_state = sda ? LSCR_IDLE : LSCR_RACK;
        end else if (sclFall) begin
          nxt_state = LSCR_RDAT;
        end
      end
      default: begin
        nxt_state = LSCR_IDLE;
      end
    endcase
    if (startSeen) begin
      nxt_state = LSCR_ADDR;
    end
    if (stopSeen || lockout) begin
      nxt_state = LSCR_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= LSCR_IDLE;
    end else if (clkEn) begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================
  // Bit counter, counts clock rises of the byte
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bitCnt_ff <= 4'h0;
    end else if (clkEn) begin
      if (startSeen || nxt_state != state_ff) begin
        bitCnt_ff <= 4'h0;
      end else if (sclRise && (state_ff == LSCR_ADDR ||
          state_ff == LSCR_WDAT || state_ff == LSCR_RDAT)) begin
        bitCnt_ff <= bitCnt_ff + 4'h1;
      end
    end
  end

  // ==========================================
  // Byte shifter
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shift_ff <= `LSCR_REG_RESET;
    end else if (clkEn) begin
      if (nxt_state == LSCR_RDAT && state_ff != LSCR_RDAT) begin
        shift_ff <= readByte;
      end else if ((state_ff == LSCR_ADDR || state_ff == LSCR_WDAT)
          && sclRise) begin
        shift_ff <= {shift_ff[6:0], sda};
      end else if (state_ff == LSCR_RDAT && sclFall) begin
        shift_ff <= {shift_ff[6:0], 1'b0};
      end
    end
  end

  // ==========================================
  // Transfer direction
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      readDir_ff <= 1'b0;
    end else if (clkEn) begin
      if (state_ff == LSCR_ADDR && nxt_state == LSCR_AACK) begin
        readDir_ff <= shift_ff[0];
      end
    end
  end

  // ==========================================
  // Register storage
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      regBits_ff <= `LSCR_REG_RESET;
    end else if (clkEn) begin
      if (lockout) begin
        regBits_ff <= `LSCR_REG_RESET;
      end else if (state_ff == LSCR_WDAT && nxt_state == LSCR_WACK) begin
        regBits_ff <= shift_ff & `LSCR_WR_MASK;
      end
    end
  end

  assign supply_control_status = readByte;

  // ==========================================
  // Data line drive
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sdaHoldLow_ff <= 1'b0;
    end else if (clkEn) begin
      if (nxt_state == LSCR_AACK || nxt_state == LSCR_WACK) begin
        sdaHoldLow_ff <= 1'b1;
      end else if (nxt_state == LSCR_RDAT) begin
        sdaHoldLow_ff <= !nextReadBit;
      end else begin
        sdaHoldLow_ff <= 1'b0;
      end
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe_n = !sdaHoldLow_ff;

  // ==========================================
  // Tone detect open-drain output
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      toneLow_ff <= 1'b0;
    end else if (clkEn) begin
      toneLow_ff <= toneSensed;
    end
  end

  assign tone_detect_out = 1'b0;
  assign tone_detect_oe_n = !toneLow_ff;

  // ==========================================
  // Supply command decode
  lscr_power_ctrl uPower (
    .clock(clock),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .regVal(regBits_ff),
    .toneGateIn(toneGate),
    .thermalHot(thermal),
    .lockout(lockout),
    .powerOn(powerOn),
    .loopThroughClosed(loopThroughClosed),
    .voutCode(voutCode),
    .toneOn(toneOn),
    .limitLow(limitLow),
    .limitStatic(limitStatic)
  );
endmodule : lscr_supply_ctrl

/* File: lscr_host.sv */
// Host-side two-wire bus master model
`timescale 1ns/10ps
module lscr_host (
  input wire logic clock,
  input wire logic sdaLine,
  output logic scl,
  output logic sdaM
);
  initial begin
    scl = 1'b1;
    sdaM = 1'b1;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge clock);
  endtask : hw
  // ==========================================
  // Framing
  task automatic start;
    hw(4);
    sdaM = 1'b0;
    hw(4);
    scl = 1'b0;
  endtask : start
  task automatic stop;
    hw(2);
    sdaM = 1'b0;
    hw(2);
    scl = 1'b1;
    hw(4);
    sdaM = 1'b1;
    hw(4);
  endtask : stop
  // Data held through the high phase
  task automatic bitx(input logic b, output logic r);
    hw(2);
    sdaM = b;
    hw(2);
    scl = 1'b1;
    hw(2);
    r = sdaLine;
    hw(2);
    scl = 1'b0;
  endtask : bitx
  task automatic xfer(input logic [7:0] d, input logic ackIn,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(ackIn, ack);
  endtask : xfer
endmodule : lscr_host

/* File: lscr_sva.sv */
// Port checks for the supply control register block
`timescale 1ns/10ps
module lscr_sva (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic lockoutIn,
  input wire logic thermalIn,
  input wire logic overloadIn,
  input wire logic toneSensedIn,
  input wire logic tone_gate_in,
  input wire logic sdaOe_n,
  input wire logic tone_detect_oe_n,
  input wire logic [7:0] supply_control_status,
  input wire logic powerOn,
  input wire logic loopThroughClosed,
  input wire logic [1:0] voutCode,
  input wire logic toneOn,
  input wire logic limitLow,
  input wire logic limitStatic
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Sequences
  sequence s_live;
    (clkEn && !lockoutIn && !thermalIn) [*4];
  endsequence
  sequence s_gateSteady;
    (clkEn && !lockoutIn && !thermalIn && $stable(tone_gate_in)) [*5];
  endsequence
  sequence s_enabled;
    s_live ##0 supply_control_status[2];
  endsequence
  // ==========================================
  // Properties
  property p_onState;
    s_enabled |=> powerOn && !loopThroughClosed &&
      voutCode == $past(supply_control_status[4:3]);
  endproperty
  a_onState: assert property (p_onState) else $error("bad on state");
  property p_offState;
    s_live ##0 !supply_control_status[2] |=> !powerOn && loopThroughClosed;
  endproperty
  a_offState: assert property (p_offState) else $error("bad off");
  property p_limits;
    s_enabled |=> limitLow == $past(supply_control_status[6]) &&
      limitStatic == $past(supply_control_status[7]);
  endproperty
  a_limits: assert property (p_limits) else $error("bad limits");
  property p_toneGate;
    s_gateSteady ##0 supply_control_status[2] && !supply_control_status[5]
      |=> toneOn == $past(tone_gate_in);
  endproperty
  a_toneGate: assert property (p_toneGate) else $error("bad keying");
  property p_toneForce;
    s_enabled ##0 supply_control_status[5] |=> toneOn;
  endproperty
  a_toneForce: assert property (p_toneForce) else $error("no tone");
  property p_thermal;
    (clkEn && thermalIn && !lockoutIn && supply_control_status[2]) [*5]
      |=> !powerOn && !loopThroughClosed;
  endproperty
  a_thermal: assert property (p_thermal) else $error("hot not off");
  property p_ovFlag;
    (clkEn && overloadIn) [*5] |-> supply_control_status[0];
  endproperty
  a_ovFlag: assert property (p_ovFlag) else $error("flag missing");
  property p_toneDet;
    (clkEn && !lockoutIn && toneSensedIn) [*5] |-> !tone_detect_oe_n;
  endproperty
  a_toneDet: assert property (p_toneDet) else $error("detect idle");
  property p_lockReg;
    lockoutIn [*5] |-> supply_control_status[7:2] == 6'h00 && sdaOe_n;
  endproperty
  a_lockReg: assert property (p_lockReg) else $error("lockout leak");
endmodule : lscr_sva
bind lscr_supply_ctrl lscr_sva u_sva (.clock(clock), .rst_n(rst_n),
  .clkEn(clkEn), .lockoutIn(lockoutIn), .thermalIn(thermalIn),
  .overloadIn(overloadIn), .toneSensedIn(toneSensedIn),
  .tone_gate_in(tone_gate_in), .sdaOe_n(sdaOe_n),
  .tone_detect_oe_n(tone_detect_oe_n),
  .supply_control_status(supply_control_status), .powerOn(powerOn),
  .loopThroughClosed(loopThroughClosed), .voutCode(voutCode),
  .toneOn(toneOn), .limitLow(limitLow), .limitStatic(limitStatic));

/* File: tb_top.sv */
// Self-checking bench for the supply control register block
`timescale 1ns/10ps
module tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic lockoutIn = 1'b0;
  logic thermalIn = 1'b0;
  logic overloadIn = 1'b0;
  logic toneSensedIn = 1'b0;
  logic toneGate = 1'b0;
  logic scl, sdaM, sdaOut, sdaOe_n, toneOut, toneOe_n;
  logic powerOn, loopThroughClosed, toneOn, limitLow, limitStatic;
  logic [1:0] voutCode;
  logic [7:0] scs;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  wire logic sdaLine = sdaM & (sdaOe_n | sdaOut);
  wire logic toneLine = toneOe_n | toneOut;
  wire logic [7:0] ctl = {powerOn, loopThroughClosed, toneOn, limitLow,
                          limitStatic, voutCode, toneLine};
  always #10 clock = ~clock;
  lscr_host u_host (.clock(clock), .sdaLine(sdaLine), .scl(scl), .sdaM(sdaM));
  lscr_supply_ctrl u_dut (.clock(clock), .rst_n(rst_n), .clkEn(clkEn),
    .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
    .lockoutIn(lockoutIn), .thermalIn(thermalIn), .overloadIn(overloadIn),
    .toneSensedIn(toneSensedIn), .tone_gate_in(toneGate),
    .tone_detect_out(toneOut), .tone_detect_oe_n(toneOe_n),
    .supply_control_status(scs), .powerOn(powerOn),
    .loopThroughClosed(loopThroughClosed), .voutCode(voutCode),
    .toneOn(toneOn), .limitLow(limitLow), .limitStatic(limitStatic));
  // ==========================================
  // Helpers
  task automatic stop_test;
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] ak);
    logic [7:0] q;
    logic a0;
    logic a1;
    u_host.start();
    u_host.xfer(a, 1'b1, q, a0);
    u_host.xfer(d, 1'b1, q, a1);
    u_host.stop();
    ak = {6'h00, a0, a1};
    idle(2);
  endtask : wr
  task automatic rd(output logic [7:0] q1, output logic [7:0] q2);
    logic a0;
    logic x;
    u_host.start();
    u_host.xfer(8'h11, 1'b1, q1, a0);
    chk({7'h00, a0}, 8'h00);
    u_host.xfer(8'hFF, 1'b0, q1, x);
    u_host.xfer(8'hFF, 1'b1, q2, x);
    u_host.stop();
    idle(2);
  endtask : rd
  // ==========================================
  // Scenarios
  task automatic t_modes;
    logic [7:0] wv [4] = '{8'h07, 8'h4C, 8'h94, 8'h3C};
    logic [7:0] e, ak, q1, q2;
    for (int i = 0; i < 4; i++) begin
      e = wv[i] & 8'hFC;
      wr(8'h10, wv[i], ak);
      chk(ak, 8'h00);
      chk(scs, e);
      rd(q1, q2);
      chk(q1, e);
      chk(q2, e);
      chk(ctl, {2'b10, e[5], e[6], e[7], e[4:3], 1'b1});
    end
  endtask : t_modes
  task automatic t_flags;
    logic [7:0] ak, q1, q2;
    thermalIn = 1'b1;
    overloadIn = 1'b1;
    idle(6);
    chk({6'h00, ctl[7:6]}, 8'h00);
    rd(q1, q2);
    chk(q1, 8'h3F);
    wr(8'h10, 8'h04, ak);
    chk(scs, 8'h07);
    thermalIn = 1'b0;
    overloadIn = 1'b0;
    idle(6);
    chk(scs, 8'h04);
  endtask : t_flags
  task automatic t_tone;
    toneGate = 1'b1;
    toneSensedIn = 1'b1;
    idle(6);
    chk(ctl, 8'hA0);
    toneGate = 1'b0;
    toneSensedIn = 1'b0;
    idle(6);
    chk(ctl, 8'h81);
    clkEn = 1'b0;
    toneSensedIn = 1'b1;
    idle(6);
    chk(ctl, 8'h81);
    clkEn = 1'b1;
    idle(6);
    chk(ctl, 8'h80);
    toneSensedIn = 1'b0;
    idle(6);
  endtask : t_tone
  task automatic t_lock;
    logic [7:0] ak;
    wr(8'h12, 8'hFC, ak);
    chk(ak, 8'h03);
    chk(scs, 8'h04);
    lockoutIn = 1'b1;
    idle(6);
    wr(8'h10, 8'hFC, ak);
    chk(ak, 8'h03);
    chk(scs, 8'h00);
    chk(ctl, 8'h41);
    lockoutIn = 1'b0;
    idle(4);
    wr(8'h10, 8'hF8, ak);
    chk(ak, 8'h00);
    chk(scs, 8'hF8);
    chk({6'h00, ctl[7:6]}, 8'h01);
  endtask : t_lock
  always @(posedge clock) begin
    cycles++;
    if (cycles > 20000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    idle(4);
    chk(scs, 8'h00);
    chk(ctl, 8'h41);
    t_modes();
    t_flags();
    t_tone();
    t_lock();
    stop_test();
  end
endmodule : tb_top
